// ===== design/pobc_pkg.sv
// package with constants and carrier types for the panel output and buzzer control block
`default_nettype none
package pobc_pkg;
    // ****
    // register map
    // ****
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_OUTCFG = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_CMD = 4'h3;
    // control field positions
    localparam int CTRL_CO_LATCH = 0;
    localparam int CTRL_CO_SUPER = 1;
    localparam int CTRL_WF_LATCH = 2;
    localparam int CTRL_WF_HELPER = 3;
    localparam int CTRL_BUZ_TRBL = 4;
    // control reset: supervisory on, waterflow latch and helper on, buzzer on trouble on
    localparam logic [7:0] CTRL_RST = 8'h1E;
    // output config: [0] norm energised, [1] supervised, [2] door holder, per output 1,2; [8] out3 ne
    localparam logic [8:0] OUTCFG_RST = 9'h022;
    // command bits
    localparam int CMD_CO_RESET = 0;
    localparam int CMD_WF_RESET = 1;
    // ****
    // timing
    // ****
    localparam longint CLK_HZ = 100_000_000;
    localparam longint ALARM_RESOUND_S = 4 * 3600;
    localparam longint TROUBLE_RESOUND_S = 24 * 3600;
    localparam longint ALARM_RESOUND_CYC = ALARM_RESOUND_S * CLK_HZ;
    localparam longint TROUBLE_RESOUND_CYC = TROUBLE_RESOUND_S * CLK_HZ;
    localparam int DEBOUNCE_CYC = 1_000_000;
    localparam int CADENCE_CYC = 25_000_000;
    localparam int BLINK_CYC = 50_000_000;
    // ****
    // carrier types
    // ****
    typedef struct packed {
        logic helper_inhibit;
        logic ack;
        logic silence;
        logic door_disable;
    } pobc_buttons_s;
    typedef struct packed {
        logic helper_led;
        logic co_led;
        logic waterflow_led;
        logic disabled_list_led;
        logic silence_led;
        logic buz_disabled_led;
        logic buz_msg_flash;
    } pobc_leds_s;
    typedef enum logic [1:0] {BUZ_IDLE, BUZ_SOUND, BUZ_SILENCED} pobc_buz_e;
endpackage
`default_nettype wire

// ===== design/pobc_debounce.sv
// debouncer with synchroniser and one-cycle press pulse for a push-button
`default_nettype none
module pobc_debounce
    import pobc_pkg::*;
#(
    parameter int STABLE_CYC = DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // button
    input wire logic btn_pin,
    output logic press
);
    logic sync1_ff, sync2_ff, level_ff;
    logic [$clog2(STABLE_CYC+1)-1:0] cnt_ff;

    // two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= btn_pin;
            sync2_ff <= sync1_ff;
        end
    end

    // level accepted only after it stays stable for the full window
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
            level_ff <= 1'b0;
            press <= 1'b0;
        end else begin
            press <= 1'b0;
            if (sync2_ff == level_ff) begin
                cnt_ff <= '0;
            end else if (cnt_ff == ($bits(cnt_ff))'(STABLE_CYC - 1)) begin
                cnt_ff <= '0;
                level_ff <= sync2_ff;
                press <= sync2_ff; // one pulse per press
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== design/pobc_sync.sv
// two-flop synchroniser for a vector of field inputs
`default_nettype none
module pobc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // data
    input wire logic [W-1:0] d_pin,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_ff;

    // first stage is read only by the second
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_ff <= '0;
            q <= '0;
        end else begin
            s1_ff <= d_pin;
            q <= s1_ff;
        end
    end
endmodule
`default_nettype wire

// ===== design/pobc_top.sv
// panel helper relay, onboard outputs, co and waterflow latching and buzzer control
// Contract
// - helper relay on: enabled device alarm with option
// - inhibit kills onboard and loop helper relays
// - inhibit entry: led, relays off, buzzer, trouble
// - ack silences; new disablement resounds buzzer
// - inhibit button toggles; led shows inhibit
// - outputs 1,2 default supervised, de-energised, configurable
// - output 3 follows mapped source or energised
// - co lights led; latch holds until reset
// - co latch defaults off, follows input
// - co makes supervisory event when flag set
// - co detector fault raises trouble
// - waterflow lights led, event names source
// - waterflow latched and drives helper by default
// - door disable toggles, holders off, led on
// - buzzer: rapid for alarm, steady for trouble
// - silence switch or ack quiets buzzer
// - new alarm or trouble resounds buzzer
// - resound after 4 h alarm, 24 h trouble
// - silence led blinks partial, steady all panels
// - buzzer on trouble is a global option
// - buzzer disable switch lights led, flashes message
`default_nettype none
module pobc_top
    import pobc_pkg::*;
#(
    parameter int N_DEV = 8,
    parameter int N_CO = 4,
    parameter int N_WF = 4,
    parameter int N_LOOP = 8,
    parameter longint ALARM_RESOUND = ALARM_RESOUND_CYC,
    parameter longint TROUBLE_RESOUND = TROUBLE_RESOUND_CYC,
    parameter int DEBOUNCE = DEBOUNCE_CYC,
    parameter int CADENCE = CADENCE_CYC,
    parameter int BLINK = BLINK_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // operator pins
    input wire pobc_buttons_s btn_pins,
    input wire logic buz_disable_pin,
    // field device states
    input wire logic [N_DEV-1:0] dev_alarm,
    input wire logic [N_DEV-1:0] dev_disabled,
    input wire logic [N_DEV-1:0] dev_helper_opt,
    input wire logic [N_CO-1:0] co_active_pin,
    input wire logic [N_CO-1:0] co_fault_pin,
    input wire logic [N_WF-1:0] wf_active_pin,
    input wire logic [N_LOOP-1:0] loop_helper_req,
    input wire logic [N_LOOP-1:0] loop_is_helper,
    input wire logic [1:0] door_req,
    input wire logic out3_source,
    input wire logic other_trouble,
    input wire logic net_silenced_any,
    input wire logic net_silenced_all,
    // relays and outputs
    output logic helper_relay,
    output logic [N_LOOP-1:0] loop_relay,
    output logic [1:0] out12_relay,
    output logic [1:0] out12_supervised,
    output logic out3_relay,
    output logic buzzer,
    output pobc_leds_s leds,
    // events
    output logic trouble,
    output logic supervisory_evt,
    output logic wf_evt,
    output logic [N_WF-1:0] wf_evt_src
);
    // ****
    // input conditioning
    // ****
    logic p_inhibit, p_ack, p_silence, p_door;
    logic [N_CO-1:0] co_act, co_flt;
    logic [N_WF-1:0] wf_act;
    logic buz_dis;

    pobc_debounce #(.STABLE_CYC(DEBOUNCE)) u_db_inh (.core_clk(core_clk), .rst(rst),
        .btn_pin(btn_pins.helper_inhibit), .press(p_inhibit));
    pobc_debounce #(.STABLE_CYC(DEBOUNCE)) u_db_ack (.core_clk(core_clk), .rst(rst),
        .btn_pin(btn_pins.ack), .press(p_ack));
    pobc_debounce #(.STABLE_CYC(DEBOUNCE)) u_db_sil (.core_clk(core_clk), .rst(rst),
        .btn_pin(btn_pins.silence), .press(p_silence));
    pobc_debounce #(.STABLE_CYC(DEBOUNCE)) u_db_door (.core_clk(core_clk), .rst(rst),
        .btn_pin(btn_pins.door_disable), .press(p_door));
    pobc_sync #(.W(2 * N_CO + N_WF + 1)) u_sync (.core_clk(core_clk), .rst(rst),
        .d_pin({co_active_pin, co_fault_pin, wf_active_pin, buz_disable_pin}),
        .q({co_act, co_flt, wf_act, buz_dis}));

    // ****
    // registers
    // ****
    logic [7:0] ctrl_ff;
    logic [8:0] outcfg_ff;
    logic co_reset, wf_reset;
    logic [15:0] status;

    // software-written configuration
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= CTRL_RST;
            outcfg_ff <= OUTCFG_RST;
        end else if (reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                ctrl_ff <= reg_wdata[7:0];
            end
            if (reg_addr == REG_OUTCFG) begin
                outcfg_ff <= reg_wdata[8:0];
            end
        end
    end

    assign co_reset = reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_CO_RESET];
    assign wf_reset = reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_WF_RESET];

    // read data stands the cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL: reg_rdata <= {8'h00, ctrl_ff};
                REG_OUTCFG: reg_rdata <= {7'h00, outcfg_ff};
                REG_STATUS: reg_rdata <= status;
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ****
    // helper relay inhibit and door disable
    // ****
    logic inhibit_ff, door_dis_ff;

    // alternate presses toggle each function
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            inhibit_ff <= 1'b0;
            door_dis_ff <= 1'b0;
        end else begin
            if (p_inhibit) begin
                inhibit_ff <= !inhibit_ff;
            end
            if (p_door) begin
                door_dis_ff <= !door_dis_ff;
            end
        end
    end

    // ****
    // carbon monoxide and waterflow latches
    // ****
    logic [N_CO-1:0] co_latch_ff, co_state, co_prev_ff, co_flt_prev_ff;
    logic [N_WF-1:0] wf_latch_ff, wf_state, wf_prev_ff;
    logic co_any, wf_any, co_trouble;

    // latch held until panel reset; set wins over reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            co_latch_ff <= '0;
            wf_latch_ff <= '0;
        end else begin
            co_latch_ff <= (co_reset ? '0 : co_latch_ff) | co_act;
            wf_latch_ff <= (wf_reset ? '0 : wf_latch_ff) | wf_act;
        end
    end

    assign co_state = ctrl_ff[CTRL_CO_LATCH] ? (co_latch_ff | co_act) : co_act;
    assign wf_state = ctrl_ff[CTRL_WF_LATCH] ? (wf_latch_ff | wf_act) : wf_act;
    assign co_any = |co_state;
    assign wf_any = |wf_state;
    assign co_trouble = |co_flt;

    // rising edges make the event pulses
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            co_prev_ff <= '0;
            wf_prev_ff <= '0;
            co_flt_prev_ff <= '0;
            supervisory_evt <= 1'b0;
            wf_evt <= 1'b0;
            wf_evt_src <= '0;
        end else begin
            co_prev_ff <= co_state;
            wf_prev_ff <= wf_state;
            co_flt_prev_ff <= co_flt;
            supervisory_evt <= ctrl_ff[CTRL_CO_SUPER] && |(co_state & ~co_prev_ff);
            wf_evt <= |(wf_state & ~wf_prev_ff);
            wf_evt_src <= wf_state & ~wf_prev_ff;
        end
    end

    // ****
    // relays
    // ****
    logic helper_req;
    assign helper_req = |(dev_alarm & ~dev_disabled & dev_helper_opt)
        || (ctrl_ff[CTRL_WF_HELPER] && wf_any);

    // relay drives registered; inhibit forces every helper relay off
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            helper_relay <= 1'b0;
            loop_relay <= '0;
            out12_relay <= 2'b00;
            out3_relay <= 1'b0;
        end else begin
            helper_relay <= helper_req && !inhibit_ff;
            loop_relay <= loop_helper_req & ~({N_LOOP{inhibit_ff}} & loop_is_helper);
            for (int i = 0; i < 2; i++) begin
                // door holders are dropped while disabled
                out12_relay[i] <= (outcfg_ff[4*i] || door_req[i])
                    && !(outcfg_ff[4*i+2] && door_dis_ff);
            end
            out3_relay <= outcfg_ff[8] || out3_source;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out12_supervised <= 2'b00;
        end else begin
            out12_supervised <= {outcfg_ff[5], outcfg_ff[1]};
        end
    end

    // ****
    // buzzer
    // ****
    pobc_buz_e buz_st_ff;
    logic alarm_any, trbl_any, trbl_sound, trbl_prev_ff, inh_prev_ff;
    logic [N_DEV-1:0] dev_prev_ff;
    logic new_cond, resound;
    logic [47:0] sil_cnt_ff;
    logic [$clog2(CADENCE+1)-1:0] cad_cnt_ff;
    logic [$clog2(BLINK+1)-1:0] blk_cnt_ff;
    logic cad_ff, blk_ff;

    assign alarm_any = |dev_alarm || wf_any;
    assign trbl_any = other_trouble || co_trouble || inhibit_ff;
    assign trbl_sound = trbl_any && ctrl_ff[CTRL_BUZ_TRBL];
    // a fresh alarm, trouble, or fresh inhibit counts as new
    assign new_cond = |(dev_alarm & ~dev_prev_ff) || |(wf_state & ~wf_prev_ff)
        || (trbl_sound && !trbl_prev_ff) || (inhibit_ff && !inh_prev_ff)
        || |(co_flt & ~co_flt_prev_ff);
    assign resound = (alarm_any && sil_cnt_ff >= 48'(ALARM_RESOUND))
        || (sil_cnt_ff >= 48'(TROUBLE_RESOUND));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dev_prev_ff <= '0;
            trbl_prev_ff <= 1'b0;
            inh_prev_ff <= 1'b0;
        end else begin
            dev_prev_ff <= dev_alarm;
            trbl_prev_ff <= trbl_sound;
            inh_prev_ff <= inhibit_ff;
        end
    end

    // new conditions win over silence in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            buz_st_ff <= BUZ_IDLE;
        end else begin
            unique case (buz_st_ff)
                BUZ_IDLE: if (alarm_any || trbl_sound) buz_st_ff <= BUZ_SOUND;
                BUZ_SOUND: begin
                    if (!(alarm_any || trbl_sound)) begin
                        buz_st_ff <= BUZ_IDLE;
                    end else if ((p_silence || p_ack) && !new_cond) begin
                        buz_st_ff <= BUZ_SILENCED;
                    end
                end
                BUZ_SILENCED: begin
                    if (!(alarm_any || trbl_sound)) begin
                        buz_st_ff <= BUZ_IDLE;
                    end else if (new_cond || resound) begin
                        buz_st_ff <= BUZ_SOUND;
                    end
                end
            endcase
        end
    end

    // silence timer counts while silenced
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sil_cnt_ff <= '0;
        end else if (buz_st_ff == BUZ_SILENCED) begin
            sil_cnt_ff <= sil_cnt_ff + 48'h1;
        end else begin
            sil_cnt_ff <= '0;
        end
    end

    // free-running cadence and blink dividers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cad_cnt_ff <= '0;
            blk_cnt_ff <= '0;
            cad_ff <= 1'b0;
            blk_ff <= 1'b0;
        end else begin
            if (cad_cnt_ff == ($bits(cad_cnt_ff))'(CADENCE - 1)) begin
                cad_cnt_ff <= '0;
                cad_ff <= !cad_ff;
            end else begin
                cad_cnt_ff <= cad_cnt_ff + 1'b1;
            end
            if (blk_cnt_ff == ($bits(blk_cnt_ff))'(BLINK - 1)) begin
                blk_cnt_ff <= '0;
                blk_ff <= !blk_ff;
            end else begin
                blk_cnt_ff <= blk_cnt_ff + 1'b1;
            end
        end
    end

    // alarm pattern beats trouble; local disable switch mutes the sounder only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            buzzer <= 1'b0;
            trouble <= 1'b0;
        end else begin
            buzzer <= buz_st_ff == BUZ_SOUND && !buz_dis
                && (alarm_any ? cad_ff : 1'b1);
            trouble <= trbl_any;
        end
    end

    // ****
    // leds and status
    // ****
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            leds <= '0;
        end else begin
            leds.helper_led <= inhibit_ff;
            leds.co_led <= co_any;
            leds.waterflow_led <= wf_any;
            leds.disabled_list_led <= door_dis_ff;
            leds.silence_led <= net_silenced_all ? 1'b1
                : ((net_silenced_any || buz_st_ff == BUZ_SILENCED) && blk_ff);
            leds.buz_disabled_led <= buz_dis;
            leds.buz_msg_flash <= buz_dis && blk_ff;
        end
    end

    assign status = {4'h0, buz_dis, buz_st_ff == BUZ_SILENCED, buz_st_ff == BUZ_SOUND,
        trbl_any, alarm_any, co_trouble, wf_any, co_any, door_dis_ff, inhibit_ff,
        helper_relay, out3_relay};
endmodule
`default_nettype wire

// ===== verif/pobc_chk.sv
// port-level checks for the panel output and buzzer control block
`default_nettype none
module pobc_chk
    import pobc_pkg::*;
#(
    parameter int N_DEV = 8,
    parameter int N_CO = 4,
    parameter int N_WF = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // watched inputs
    input wire logic reg_rd,
    input wire logic buz_disable_pin,
    input wire logic [N_DEV-1:0] dev_alarm,
    input wire logic [N_DEV-1:0] dev_disabled,
    input wire logic [N_DEV-1:0] dev_helper_opt,
    input wire logic [N_CO-1:0] co_active_pin,
    // watched outputs
    input wire logic [15:0] reg_rdata,
    input wire logic helper_relay,
    input wire logic buzzer,
    input wire pobc_leds_s leds,
    input wire logic trouble,
    input wire logic supervisory_evt,
    input wire logic wf_evt,
    input wire logic [N_WF-1:0] wf_evt_src
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // checks
    // ****
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // enabled device alarm with option, inhibit off
    sequence helper_req_s;
        (|(dev_alarm & ~dev_disabled & dev_helper_opt))[*3] ##0 !leds.helper_led;
    endsequence
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its slot");
    inhibit_relay_a: assert property (leds.helper_led |-> !helper_relay)
        else $error("helper relay on while inhibited");
    inhibit_trouble_a: assert property ($rose(leds.helper_led) |-> ##[0:1] trouble)
        else $error("inhibit entry without trouble");
    helper_drive_a: assert property (
        helper_req_s ##0 !$past(leds.helper_led) |-> helper_relay)
        else $error("helper relay not driven");
    alarm_led_a: assert property ((|co_active_pin)[*5] |-> leds.co_led)
        else $error("activation led dark");
    buz_mute_a: assert property (
        buz_disable_pin[*5] |-> leds.buz_disabled_led && !buzzer)
        else $error("buzzer disable switch ignored");
    evt_pulse_a: assert property (supervisory_evt |=> !supervisory_evt)
        else $error("supervisory event longer than one cycle");
    wf_source_a: assert property (
        wf_evt |-> (wf_evt_src != '0) ##[0:2] leds.waterflow_led)
        else $error("waterflow event without source or led");
    // main scenarios reached
    cover property ($rose(leds.helper_led));
    cover property (wf_evt);
    cover property ($fell(buzzer) ##1 !buzzer[*4]);
endmodule
bind pobc_top pobc_chk #(.N_DEV(N_DEV), .N_CO(N_CO), .N_WF(N_WF)) u_chk (.core_clk, .rst,
    .reg_rd, .buz_disable_pin, .dev_alarm, .dev_disabled, .dev_helper_opt, .co_active_pin,
    .reg_rdata, .helper_relay, .buzzer, .leds, .trouble, .supervisory_evt, .wf_evt,
    .wf_evt_src);
`default_nettype wire

// ===== verif/pobc_field.sv
// bouncing push-button model for the front-panel operator
`default_nettype none
module pobc_field
    import pobc_pkg::*;
(
    // clock
    input wire logic core_clk,
    // one-cycle press request from the bench
    input wire logic [3:0] push,
    // raw button pins
    output var pobc_buttons_s btn_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] held = 4'h0;
    int cnt = 99;
    // ****
    // press
    // ****
    // a one-cycle contact bounce precedes the held press, so a naive edge fires twice
    always @(posedge core_clk) begin
        if (push != 4'h0) begin
            held <= push;
            cnt <= 0;
        end else if (cnt < 99) begin
            cnt <= cnt + 1;
        end
    end
    assign btn_pins = pobc_buttons_s'((cnt == 0 || (cnt > 1 && cnt < 12)) ? held : 4'h0);
endmodule
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the panel output and buzzer control block
`default_nettype none
module tb
    import pobc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [3:0] a; logic w; logic [15:0] d; logic [15:0] e;} pobc_row_s;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic buz_disable_pin = 1'b0;
    logic [7:0] dev_alarm = 8'h00;
    logic [7:0] dev_disabled = 8'h00;
    logic [7:0] dev_helper_opt = 8'h04;
    logic [3:0] co_active_pin = 4'h0;
    logic [3:0] co_fault_pin = 4'h0;
    logic [3:0] wf_active_pin = 4'h0;
    logic [7:0] loop_helper_req = 8'hFF;
    logic [7:0] loop_is_helper = 8'h0F;
    logic [1:0] door_req = 2'h0;
    logic out3_source = 1'b0;
    logic other_trouble = 1'b0;
    logic net_silenced_any = 1'b0;
    logic net_silenced_all = 1'b0;
    logic [3:0] push = 4'h0;
    logic [3:0] wf_seen = 4'h0;
    logic [15:0] reg_rdata;
    logic helper_relay, out3_relay, buzzer, trouble, supervisory_evt, wf_evt;
    logic [7:0] loop_relay;
    logic [1:0] out12_relay, out12_supervised;
    logic [3:0] wf_evt_src;
    pobc_leds_s leds;
    pobc_buttons_s btn_pins;
    int n_fail = 0;
    int checks_done = 0;
    int n_sup = 0;
    // register cases: address, write, data, expected read
    pobc_row_s rows [6] = '{'{4'h0, 1'b0, 16'h0000, 16'h001E}, '{4'h1, 1'b0, 16'h0000, 16'h0022},
        '{4'hF, 1'b0, 16'h0000, 16'h0000}, '{4'hF, 1'b1, 16'h1234, 16'h0000},
        '{4'h1, 1'b1, 16'h0006, 16'h0006}, '{4'h0, 1'b1, 16'h001F, 16'h001F}};
    pobc_field field (.core_clk, .push, .btn_pins);
    pobc_top #(.DEBOUNCE(4), .CADENCE(4), .BLINK(8), .ALARM_RESOUND(100), .TROUBLE_RESOUND(300))
        uut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .btn_pins,
        .buz_disable_pin, .dev_alarm, .dev_disabled, .dev_helper_opt, .co_active_pin,
        .co_fault_pin, .wf_active_pin, .loop_helper_req, .loop_is_helper, .door_req,
        .out3_source, .other_trouble, .net_silenced_any, .net_silenced_all, .helper_relay,
        .loop_relay, .out12_relay, .out12_supervised, .out3_relay, .buzzer, .leds, .trouble,
        .supervisory_evt, .wf_evt, .wf_evt_src);
    always #5 core_clk = ~core_clk;
    // ****
    // tasks
    // ****
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // levels are looked at on the falling edge, clear of register updates
    task automatic wn(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h saw %h", nm, e, s);
        end
    endtask
    // cadence judged by how many of 16 cycles the buzzer is on
    task automatic bz(input string nm, input int lo, input int hi);
        int n;
        n = 0;
        repeat (16) begin
            @(negedge core_clk);
            if (buzzer === 1'b1) n++;
        end
        chk(nm, 16'(n >= lo && n <= hi), 16'h0001);
    endtask
    task automatic press(input logic [3:0] m);
        @(posedge core_clk);
        push <= m;
        @(posedge core_clk);
        push <= 4'h0;
        wn(40);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk("reg", reg_rdata, e);
    endtask
    task automatic conclude();
        if (n_fail == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // supervisory pulses are counted and the waterflow source is captured so no single sample can miss them
    always @(negedge core_clk) begin
        if (supervisory_evt === 1'b1) n_sup++;
        if (wf_evt === 1'b1) wf_seen = wf_evt_src;
    end
    initial begin
        #200us;
        n_fail++;
        conclude();
    end
    // ****
    // sequence
    // ****
    initial begin
        wt(16);
        rst <= 1'b0;
        wn(4);
        chk("supervised", 16'(out12_supervised), 16'h0003);
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        wt(1);
        dev_alarm <= 8'h04;
        wn(4);
        chk("helper", 16'(helper_relay), 16'h0001);
        bz("alarm", 2, 14);
        wt(1);
        dev_disabled <= 8'h04;
        wn(4);
        chk("helper dis", 16'(helper_relay), 16'h0000);
        wt(1);
        dev_disabled <= 8'h00;
        press(4'h2);
        bz("silenced", 0, 0);
        wn(100);
        bz("alarm again", 2, 14);
        press(4'h2);
        wt(1);
        dev_alarm <= 8'h0C;
        bz("new alarm", 2, 14);
        wt(1);
        dev_alarm <= 8'h00;
        press(4'h8);
        chk("inh led", 16'(leds.helper_led), 16'h0001);
        chk("inh trouble", 16'(trouble), 16'h0001);
        chk("loop", 16'(loop_relay), 16'h00F0);
        bz("inh buzzer", 16, 16);
        wt(1);
        dev_alarm <= 8'h04;
        wn(4);
        chk("inh helper", 16'(helper_relay), 16'h0000);
        wt(1);
        dev_alarm <= 8'h00;
        press(4'h4);
        bz("ack", 0, 0);
        press(4'h8);
        chk("inh off", 16'(leds.helper_led), 16'h0000);
        chk("loop on", 16'(loop_relay), 16'h00FF);
        press(4'h8);
        bz("redisable", 16, 16);
        press(4'h2);
        bz("quiet", 0, 0);
        wn(300);
        bz("trouble again", 16, 16);
        press(4'h8);
        wr(REG_CTRL, 16'h000F);
        co_fault_pin <= 4'h1;
        wn(6);
        chk("fault", 16'(trouble), 16'h0001);
        bz("no trouble tone", 0, 0);
        wr(REG_CTRL, 16'h001F);
        co_fault_pin <= 4'h0;
        co_active_pin <= 4'h1;
        wt(3);
        co_active_pin <= 4'h0;
        wn(8);
        chk("latched", 16'(leds.co_led), 16'h0001);
        chk("sup evt", 16'(n_sup), 16'h0001);
        wr(REG_CMD, 16'h0001);
        wn(3);
        chk("cleared", 16'(leds.co_led), 16'h0000);
        wr(REG_CTRL, 16'h001E);
        co_active_pin <= 4'h2;
        wn(8);
        chk("follow", 16'(leds.co_led), 16'h0001);
        wt(1);
        co_active_pin <= 4'h0;
        wn(6);
        chk("drop", 16'(leds.co_led), 16'h0000);
        wt(1);
        wf_active_pin <= 4'h2;
        wt(3);
        wf_active_pin <= 4'h0;
        wn(8);
        chk("wf led", 16'(leds.waterflow_led), 16'h0001);
        chk("wf src", 16'(wf_seen), 16'h0002);
        chk("wf helper", 16'(helper_relay), 16'h0001);
        wr(REG_CMD, 16'h0002);
        door_req <= 2'b01;
        wn(4);
        chk("wf clear", 16'(leds.waterflow_led), 16'h0000);
        chk("door", 16'(out12_relay), 16'h0001);
        press(4'h1);
        chk("door led", 16'(leds.disabled_list_led), 16'h0001);
        chk("door off", 16'(out12_relay), 16'h0000);
        press(4'h1);
        chk("door back", 16'(out12_relay), 16'h0001);
        wt(1);
        out3_source <= 1'b1;
        wn(4);
        chk("out3", 16'(out3_relay), 16'h0001);
        wr(REG_OUTCFG, 16'h0106);
        out3_source <= 1'b0;
        buz_disable_pin <= 1'b1;
        dev_alarm <= 8'h04;
        net_silenced_all <= 1'b1;
        wn(6);
        chk("out3 ne", 16'(out3_relay), 16'h0001);
        chk("mute led", 16'(leds.buz_disabled_led), 16'h0001);
        chk("sil led", 16'(leds.silence_led), 16'h0001);
        bz("muted", 0, 0);
        conclude();
    end
endmodule
`default_nettype wire
